// ### verification/energy_accumulator_test.sv
// Self-checking bench for the energy accumulator
module energy_accumulator_test;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [7:0] cfg;
    int ia;
    int ib;
    int ic;
    logic [7:0] dv;
    logic [11:0] ga;
  } case_type;

  logic clk;
  logic rstn;
  logic signed [15:0] volt_a, volt_b, volt_c;
  logic signed [15:0] curr_a, curr_b, curr_c;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [23:0] reg_wdata;
  logic [23:0] reg_rdata;
  logic irq_n_out;
  logic irq_oe;
  logic [23:0] rd;
  int mismatches = 0;
  int compares = 0;

  // Formula, select, divider and gain cases; currents in sample units
  case_type cases [9] = '{
    '{8'h38, 16384, 8192, 16384, 8'h00, 12'h000},
    '{8'h78, 16384, 8192, 16384, 8'h00, 12'h000},
    '{8'hB8, 16384, 8192, 16384, 8'h00, 12'h000},
    '{8'hF8, 16384, 8192, 16384, 8'h00, 12'h000},
    '{8'h28, 16384, 8192, 16384, 8'h00, 12'h000},
    '{8'h38, -16384, -8192, -16384, 8'h00, 12'h000},
    '{8'h38, 16384, 8192, 16384, 8'h04, 12'h000},
    '{8'h38, 16384, 8192, 16384, 8'h01, 12'h000},
    '{8'h38, 16384, 8192, 16384, 8'h00, 12'h7FF}
  };

  energy_accumulator energy_accumulator_inst (
    .clk(clk), .rstn(rstn),
    .volt_a(volt_a), .volt_b(volt_b), .volt_c(volt_c),
    .curr_a(curr_a), .curr_b(curr_b), .curr_c(curr_c),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .irq_n_out(irq_n_out), .irq_oe(irq_oe)
  );

  reg_host reg_host_inst (
    .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(string name, logic [23:0] seen, logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Tick phase and filter settling leave one LSB of slack
  task automatic near(string name, logic [23:0] seen, longint exp);
    longint d;
    logic [23:0] e;
    d = longint'($signed(seen)) - exp;
    if ((d >= -1) && (d <= 1))
      e = seen;
    else
      e = exp[23:0];
    check(name, seen, e);
  endtask : near

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if ((mismatches == 0) && (compares > 0))
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // Energy after 1024 ticks, worked out from the formula table
  function automatic longint exp_energy(case_type c);
    longint a, b, k;
    logic [1:0] f;
    logic d;
    f = c.cfg[7:6];
    d = (f == 2'h1) || (f == 2'h2);
    a = longint'(16384) * (d ? c.ia - c.ib : c.ia) / 32;
    b = d ? 0 : longint'(16384) * c.ib / 32;
    k = longint'(16384) * ((f == 2'h1) ? c.ic - c.ib : c.ic) / 32;
    a = a * (4096 + int'($signed(c.ga))) / 4096;
    a = (c.cfg[5] ? a : 0) + (c.cfg[4] ? b : 0) + (c.cfg[3] ? k : 0);
    return a * 1024 / (64'sd1 << 30) / ((c.dv == 8'h00) ? 1 : int'(c.dv));
  endfunction : exp_energy

  // Addresses 0 to 14 after reset, unmapped ones included
  task automatic test_reset();
    logic [23:0] e;
    for (int a = 0; a < 15; a++)
    begin
      reg_host_inst.rd_reg(a[7:0], rd);
      e = (a[7:0] == energy_acc_pkg::ADDR_SUM_CFG)
        ? {16'h0000, energy_acc_pkg::RST_SUM_CFG} : 24'h000000;
      check("reset value", rd, e);
    end
    check("irq drive", {23'h0, irq_oe}, 24'h0);
    check("irq level", {23'h0, irq_n_out}, 24'h0);
  endtask : test_reset

  // Writable widths, read-only and unmapped writes ignored; all phases off
  // so the offsets cannot move the accumulator behind the energy readback
  task automatic test_rw();
    logic [7:0] ad [8] = '{energy_acc_pkg::ADDR_OFFSET_A,
      energy_acc_pkg::ADDR_OFFSET_C, energy_acc_pkg::ADDR_DIVIDER,
      energy_acc_pkg::ADDR_PULSE_NUM, energy_acc_pkg::ADDR_GAIN_B,
      energy_acc_pkg::ADDR_ENERGY, 8'h0E, energy_acc_pkg::ADDR_IRQ_EN};
    logic [23:0] ex [8] = '{24'h000800, 24'h0007FF, 24'h0000FF,
      24'h000ABC, 24'h000123, 24'h000000, 24'h000000, 24'h000001};
    reg_host_inst.wr_reg(energy_acc_pkg::ADDR_SUM_CFG, 24'h000000);
    for (int i = 0; i < 8; i++)
      reg_host_inst.wr_reg(ad[i], ex[i] | 24'hFF0000);
    for (int i = 0; i < 8; i++)
    begin
      reg_host_inst.rd_reg(ad[i], rd);
      check("readback", rd, ex[i]);
      reg_host_inst.wr_reg(ad[i], 24'h000000);
    end
    reg_host_inst.wr_reg(energy_acc_pkg::ADDR_SUM_CFG,
      {16'h0000, energy_acc_pkg::RST_SUM_CFG});
  endtask : test_rw

  // One phase at a time with negative power, then deselected
  task automatic test_reverse();
    for (int p = 0; p < 3; p++)
    begin
      @(negedge clk);
      curr_a = (p == 0) ? 16'hF000 : 16'h1000;
      curr_b = (p == 1) ? 16'hF000 : 16'h1000;
      curr_c = (p == 2) ? 16'hF000 : 16'h1000;
      repeat (300) @(negedge clk);
      reg_host_inst.rd_reg(energy_acc_pkg::ADDR_PULSE_NUM, rd);
      check("reverse bits", rd & 24'h7000, 24'h1000 << p);
      reg_host_inst.wr_reg(energy_acc_pkg::ADDR_SUM_CFG,
        24'h38 & ~(24'h20 >> p));
      reg_host_inst.rd_reg(energy_acc_pkg::ADDR_PULSE_NUM, rd);
      check("masked reverse", rd & 24'h7000, 24'h0);
      reg_host_inst.wr_reg(energy_acc_pkg::ADDR_SUM_CFG, 24'h000038);
    end
  endtask : test_reverse

  // Accumulate over 1024 ticks, then plain, clearing and plain reads
  task automatic test_energy();
    longint e;
    for (int i = 0; i < 9; i++)
    begin
      e = exp_energy(cases[i]);
      reg_host_inst.wr_reg(energy_acc_pkg::ADDR_SUM_CFG,
        {16'h0, cases[i].cfg});
      reg_host_inst.wr_reg(energy_acc_pkg::ADDR_DIVIDER, {16'h0, cases[i].dv});
      // Trim through power gain only; currents stay unscaled
      reg_host_inst.wr_reg(energy_acc_pkg::ADDR_GAIN_A,
        {12'h0, cases[i].ga});
      @(negedge clk);
      curr_a = cases[i].ia[15:0];
      curr_b = cases[i].ib[15:0];
      curr_c = cases[i].ic[15:0];
      repeat (400) @(negedge clk);
      reg_host_inst.rd_reg(energy_acc_pkg::ADDR_ENERGY_CLR, rd);
      // 4096 edges from the clearing edge to the value read: 1024 ticks
      repeat (4095) @(negedge clk);
      reg_host_inst.rd_reg(energy_acc_pkg::ADDR_ENERGY, rd);
      near("energy", rd, e);
      reg_host_inst.rd_reg(energy_acc_pkg::ADDR_ENERGY_CLR, rd);
      near("clearing read", rd, e);
      reg_host_inst.rd_reg(energy_acc_pkg::ADDR_ENERGY, rd);
      near("after clear", rd, 0);
    end
  endtask : test_energy

  // Main sequence
  initial
  begin
    rstn = 1'b0;
    volt_a = 16'h4000;
    volt_b = 16'h4000;
    volt_c = 16'h4000;
    curr_a = 16'h0000;
    curr_b = 16'h0000;
    curr_c = 16'h0000;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    test_reset();
    test_rw();
    test_reverse();
    test_energy();
    end_sim();
  end

  // Watchdog, well past the roughly 42000 cycles the tests need
  initial
  begin
    repeat (80000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule : energy_accumulator_test

// ### verification/reg_host.sv
// Host side of the register port, driven at the falling edge
module reg_host (
  input wire logic clk, // System clock
  output logic [7:0] reg_addr, // Register address
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  output logic [23:0] reg_wdata, // Write data
  input wire logic [23:0] reg_rdata // Read data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus from time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 24'h000000;
  end

  // One write; idle lines scrambled so stale values never look valid
  task automatic wr_reg(input logic [7:0] a, input logic [23:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr_reg

  // One read; data is settled half a cycle after the edge that takes it
  task automatic rd_reg(input logic [7:0] a, output logic [23:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    d = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : rd_reg
endmodule : reg_host

// ### verilog/energy_acc_pkg.sv
package energy_acc_pkg;
  // Register addresses on the internal register port
  localparam logic [7:0] ADDR_ENERGY = 8'h01;
  localparam logic [7:0] ADDR_ENERGY_CLR = 8'h02;
  localparam logic [7:0] ADDR_DIVIDER = 8'h03;
  localparam logic [7:0] ADDR_SUM_CFG = 8'h04;
  localparam logic [7:0] ADDR_PULSE_NUM = 8'h05;
  localparam logic [7:0] ADDR_OFFSET_A = 8'h06;
  localparam logic [7:0] ADDR_OFFSET_B = 8'h07;
  localparam logic [7:0] ADDR_OFFSET_C = 8'h08;
  localparam logic [7:0] ADDR_GAIN_A = 8'h09;
  localparam logic [7:0] ADDR_GAIN_B = 8'h0A;
  localparam logic [7:0] ADDR_GAIN_C = 8'h0B;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0D;

  // Widths
  localparam int SAMPLE_W = 16;
  localparam int IDIFF_W = 17;
  localparam int BUS_W = 28;
  localparam int TERM_W = 29;
  localparam int OFFSET_W = 12;
  localparam int GAIN_W = 12;
  localparam int ACC_W = 54;
  localparam int ENERGY_W = 24;
  localparam int DATA_W = 24;
  localparam int NUM_W = 12;

  // Field positions
  localparam int FORMULA_LSB = 6;
  localparam int SEL_A_BIT = 5;
  localparam int SEL_B_BIT = 4;
  localparam int SEL_C_BIT = 3;
  localparam int REV_A_BIT = 12;
  localparam int REV_B_BIT = 13;
  localparam int REV_C_BIT = 14;
  localparam int ENERGY_LSB = 30;
  localparam int PROD_LSB = 5;
  localparam int HALF_BIT = 22;

  // Formula codes
  localparam logic [1:0] FORMULA_WYE3 = 2'h0;
  localparam logic [1:0] FORMULA_WYE2 = 2'h1;
  localparam logic [1:0] FORMULA_DELTA = 2'h2;

  // Reset values
  localparam logic [7:0] RST_SUM_CFG = 8'h38;
  localparam logic [7:0] RST_DIVIDER = 8'h00;
  localparam logic [11:0] RST_OFFSET = 12'h000;
  localparam logic [11:0] RST_GAIN = 12'h000;
  localparam logic [11:0] RST_PULSE_NUM = 12'h000;

  // Timing and arithmetic
  localparam int TICK_CYCLES = 4;
  localparam int LPF_SHIFT = 4;
  localparam int GAIN_SHIFT = 12;
  localparam logic [13:0] GAIN_UNITY = 14'h1000;
endpackage : energy_acc_pkg

// ### verilog/energy_accumulator.sv
// Polyphase total active power and energy accumulator
module energy_accumulator (
  input wire logic clk, // 40 MHz system clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic signed [15:0] volt_a, // Phase A voltage sample
  input wire logic signed [15:0] volt_b, // Phase B voltage sample
  input wire logic signed [15:0] volt_c, // Phase C voltage sample
  input wire logic signed [15:0] curr_a, // Phase A corrected current
  input wire logic signed [15:0] curr_b, // Phase B corrected current
  input wire logic signed [15:0] curr_c, // Phase C corrected current
  input wire logic [7:0] reg_addr, // Register address
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [23:0] reg_wdata, // Register write data
  output logic [23:0] reg_rdata, // Register read data, next cycle
  output logic irq_n_out, // Interrupt pin level when driven
  output logic irq_oe // Interrupt pin drive enable
);
  logic rst_meta_ff;
  logic rst_n;
  logic [1:0] tick_cnt_ff;
  logic tick;
  logic [7:0] sum_cfg_ff;
  logic [7:0] divider_ff;
  logic [11:0] pulse_num_ff;
  logic [11:0] offset_a_ff;
  logic [11:0] offset_b_ff;
  logic [11:0] offset_c_ff;
  logic [11:0] gain_a_ff;
  logic [11:0] gain_b_ff;
  logic [11:0] gain_c_ff;
  logic irq_en_ff;
  logic irq_stat_ff;
  logic [23:0] rdata_ff;
  logic irq_oe_ff;
  logic [1:0] formula;
  logic sel_a;
  logic sel_b;
  logic sel_c;
  logic term_b_en;
  logic signed [16:0] ia_x;
  logic signed [16:0] ib_x;
  logic signed [16:0] ic_x;
  logic signed [16:0] idiff_a;
  logic signed [16:0] idiff_c;
  logic signed [28:0] term_a;
  logic signed [28:0] term_b;
  logic signed [28:0] term_c;
  logic neg_a;
  logic neg_b;
  logic neg_c;
  logic [2:0] rev_bits;
  logic signed [30:0] total;
  logic signed [53:0] total_ext;
  logic signed [53:0] acc_ff;
  logic [53:0] div_eff;
  logic signed [53:0] quot;
  logic [23:0] energy_ff;
  logic half_ff;
  logic half_now;
  logic half_evt;
  logic clr_rd;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_ff <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n <= rst_meta_ff;
    end
  end

  // Accumulation cadence divider
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_ff <= 2'h0;
    else if (tick)
      tick_cnt_ff <= 2'h0;
    else
      tick_cnt_ff <= tick_cnt_ff + 2'h1;
  end
  assign tick = (tick_cnt_ff
    == 2'(energy_acc_pkg::TICK_CYCLES - 1));

  // Configuration fields
  assign formula = sum_cfg_ff[energy_acc_pkg::FORMULA_LSB +: 2];
  assign sel_a = sum_cfg_ff[energy_acc_pkg::SEL_A_BIT];
  assign sel_b = sum_cfg_ff[energy_acc_pkg::SEL_B_BIT];
  assign sel_c = sum_cfg_ff[energy_acc_pkg::SEL_C_BIT];
  // Code 3 is undefined and falls back to the three-product sum
  assign term_b_en = sel_b && (formula != energy_acc_pkg::FORMULA_WYE2)
    && (formula != energy_acc_pkg::FORMULA_DELTA);

  // Current terms per formula; inputs are already corrected upstream
  assign ia_x = {curr_a[15], curr_a};
  assign ib_x = {curr_b[15], curr_b};
  assign ic_x = {curr_c[15], curr_c};
  assign idiff_a = (formula == energy_acc_pkg::FORMULA_WYE2
    || formula == energy_acc_pkg::FORMULA_DELTA)
    ? ia_x - ib_x : ia_x;
  assign idiff_c = (formula == energy_acc_pkg::FORMULA_WYE2)
    ? ic_x - ib_x : ic_x;

  // Three identical phase chains
  phase_term u_term_a (
    .clk(clk),
    .rst_n(rst_n),
    .volt(volt_a),
    .curr(idiff_a),
    .offset(offset_a_ff),
    .gain(gain_a_ff),
    .term_ff(term_a),
    .negative(neg_a)
  );
  phase_term u_term_b (
    .clk(clk),
    .rst_n(rst_n),
    .volt(volt_b),
    .curr(ib_x),
    .offset(offset_b_ff),
    .gain(gain_b_ff),
    .term_ff(term_b),
    .negative(neg_b)
  );
  phase_term u_term_c (
    .clk(clk),
    .rst_n(rst_n),
    .volt(volt_c),
    .curr(idiff_c),
    .offset(offset_c_ff),
    .gain(gain_c_ff),
    .term_ff(term_c),
    .negative(neg_c)
  );

  // Reverse power only for selected phases, phase B even where the formula drops its term
  assign rev_bits = {neg_c & sel_c, neg_b & sel_b,
    neg_a & sel_a};

  // Total of the selected terms
  assign total = (sel_a ? {{2{term_a[28]}}, term_a} : 31'sh0)
    + (term_b_en ? {{2{term_b[28]}}, term_b} : 31'sh0)
    + (sel_c ? {{2{term_c[28]}}, term_c} : 31'sh0);
  assign total_ext = {{23{total[30]}}, total};

  // Clearing read zeroes the accumulator; a same-cycle add survives
  assign clr_rd = reg_rd && (reg_addr == energy_acc_pkg::ADDR_ENERGY_CLR);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      acc_ff <= 54'sh0;
    else if (clr_rd)
      acc_ff <= tick ? total_ext : 54'sh0;
    else if (tick)
      acc_ff <= acc_ff + total_ext;
  end

  // Division; zero divider acts as one, wrap follows two's complement
  assign div_eff = (divider_ff == 8'h00) ? 54'h1
    : {46'h0, divider_ff};
  assign quot = acc_ff / $signed(div_eff);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      energy_ff <= 24'h000000;
    else
      energy_ff <= quot[53:energy_acc_pkg::ENERGY_LSB];
  end

  // Half scale: top two bits differ in either direction
  assign half_now = energy_ff[23] ^ energy_ff[energy_acc_pkg::HALF_BIT];
  assign half_evt = half_now && !half_ff;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      half_ff <= 1'b0;
    else
      half_ff <= half_now;
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_stat_ff <= 1'b0;
    else if (half_evt)
      irq_stat_ff <= 1'b1;
    else if (reg_wr && reg_addr == energy_acc_pkg::ADDR_IRQ_STAT
             && reg_wdata[0])
      irq_stat_ff <= 1'b0;
  end

  // Open-drain interrupt: drive low only while flagged and enabled
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_oe_ff <= 1'b0;
    else
      irq_oe_ff <= irq_stat_ff & irq_en_ff;
  end
  assign irq_oe = irq_oe_ff;
  assign irq_n_out = 1'b0;

  // Register writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sum_cfg_ff <= energy_acc_pkg::RST_SUM_CFG;
      divider_ff <= energy_acc_pkg::RST_DIVIDER;
      pulse_num_ff <= energy_acc_pkg::RST_PULSE_NUM;
      offset_a_ff <= energy_acc_pkg::RST_OFFSET;
      offset_b_ff <= energy_acc_pkg::RST_OFFSET;
      offset_c_ff <= energy_acc_pkg::RST_OFFSET;
      gain_a_ff <= energy_acc_pkg::RST_GAIN;
      gain_b_ff <= energy_acc_pkg::RST_GAIN;
      gain_c_ff <= energy_acc_pkg::RST_GAIN;
      irq_en_ff <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == energy_acc_pkg::ADDR_SUM_CFG)
        sum_cfg_ff <= reg_wdata[7:0];
      else if (reg_addr == energy_acc_pkg::ADDR_DIVIDER)
        divider_ff <= reg_wdata[7:0];
      else if (reg_addr == energy_acc_pkg::ADDR_PULSE_NUM)
        pulse_num_ff <= reg_wdata[11:0];
      else if (reg_addr == energy_acc_pkg::ADDR_OFFSET_A)
        offset_a_ff <= reg_wdata[11:0];
      else if (reg_addr == energy_acc_pkg::ADDR_OFFSET_B)
        offset_b_ff <= reg_wdata[11:0];
      else if (reg_addr == energy_acc_pkg::ADDR_OFFSET_C)
        offset_c_ff <= reg_wdata[11:0];
      else if (reg_addr == energy_acc_pkg::ADDR_GAIN_A)
        gain_a_ff <= reg_wdata[11:0];
      else if (reg_addr == energy_acc_pkg::ADDR_GAIN_B)
        gain_b_ff <= reg_wdata[11:0];
      else if (reg_addr == energy_acc_pkg::ADDR_GAIN_C)
        gain_c_ff <= reg_wdata[11:0];
      else if (reg_addr == energy_acc_pkg::ADDR_IRQ_EN)
        irq_en_ff <= reg_wdata[0];
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= 24'h000000;
    else if (reg_rd)
    begin
      if (reg_addr == energy_acc_pkg::ADDR_ENERGY)
        rdata_ff <= energy_ff;
      else if (reg_addr == energy_acc_pkg::ADDR_ENERGY_CLR)
        rdata_ff <= energy_ff;
      else if (reg_addr == energy_acc_pkg::ADDR_SUM_CFG)
        rdata_ff <= {16'h0000, sum_cfg_ff};
      else if (reg_addr == energy_acc_pkg::ADDR_DIVIDER)
        rdata_ff <= {16'h0000, divider_ff};
      else if (reg_addr == energy_acc_pkg::ADDR_PULSE_NUM)
        rdata_ff <= {9'h000, rev_bits, pulse_num_ff};
      else if (reg_addr == energy_acc_pkg::ADDR_OFFSET_A)
        rdata_ff <= {12'h000, offset_a_ff};
      else if (reg_addr == energy_acc_pkg::ADDR_OFFSET_B)
        rdata_ff <= {12'h000, offset_b_ff};
      else if (reg_addr == energy_acc_pkg::ADDR_OFFSET_C)
        rdata_ff <= {12'h000, offset_c_ff};
      else if (reg_addr == energy_acc_pkg::ADDR_GAIN_A)
        rdata_ff <= {12'h000, gain_a_ff};
      else if (reg_addr == energy_acc_pkg::ADDR_GAIN_B)
        rdata_ff <= {12'h000, gain_b_ff};
      else if (reg_addr == energy_acc_pkg::ADDR_GAIN_C)
        rdata_ff <= {12'h000, gain_c_ff};
      else if (reg_addr == energy_acc_pkg::ADDR_IRQ_EN)
        rdata_ff <= {23'h000000, irq_en_ff};
      else if (reg_addr == energy_acc_pkg::ADDR_IRQ_STAT)
        rdata_ff <= {23'h000000, irq_stat_ff};
      else
        rdata_ff <= 24'h000000;
    end
  end
  assign reg_rdata = rdata_ff;

  // Checks on the design's own behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence seq_gap3;
    !tick [*3] ##1 tick;
  endsequence

  AST_TICK_EVERY_FOUR: assert property (
    tick |=> seq_gap3)
    else $error("accumulation tick not every four cycles");

  AST_ACC_ADDS_TOTAL: assert property (
    tick && !clr_rd |=> acc_ff == $past(acc_ff) + $past(total_ext))
    else $error("accumulator did not add the total");

  AST_PLAIN_READ_KEEPS: assert property (
    reg_rd && reg_addr == energy_acc_pkg::ADDR_ENERGY && !tick
    |=> acc_ff == $past(acc_ff))
    else $error("plain energy read altered accumulator");

  AST_CLEAR_READ: assert property (
    clr_rd && !tick |=> acc_ff == 54'sh0 && rdata_ff == $past(energy_ff))
    else $error("clearing read did not zero accumulator");

  AST_REV_MASKED: assert property (
    reg_rd && reg_addr == energy_acc_pkg::ADDR_PULSE_NUM && !sel_a
    |=> !rdata_ff[energy_acc_pkg::REV_A_BIT])
    else $error("reverse bit of excluded phase not zero");

  AST_REV_READBACK: assert property (
    reg_rd && reg_addr == energy_acc_pkg::ADDR_PULSE_NUM
    |=> rdata_ff[14:12] == $past(rev_bits))
    else $error("reverse bits not at 14:12");

  AST_DIV_ZERO_IS_ONE: assert property (
    divider_ff == 8'h00 |=> energy_ff == $past(acc_ff[53:30]))
    else $error("zero divider did not act as one");

  AST_NO_B_TERM: assert property (
    formula == energy_acc_pkg::FORMULA_WYE2
    || formula == energy_acc_pkg::FORMULA_DELTA
    |-> total == (sel_a ? {{2{term_a[28]}}, term_a} : 31'sh0)
    + (sel_c ? {{2{term_c[28]}}, term_c} : 31'sh0))
    else $error("phase B term used in two-term formula");

  sequence seq_half_flag;
    irq_stat_ff ##1 (irq_oe == $past(irq_en_ff));
  endsequence

  AST_HALF_EVENT_IRQ: assert property (
    half_evt |=> seq_half_flag)
    else $error("half-full event did not set flag or interrupt");
endmodule : energy_accumulator

// ### verilog/phase_term.sv
// One phase: product, low-pass, offset and power gain
module phase_term (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic signed [energy_acc_pkg::SAMPLE_W-1:0] volt, // Voltage
  input wire logic signed [energy_acc_pkg::IDIFF_W-1:0] curr, // Current term
  input wire logic signed [energy_acc_pkg::OFFSET_W-1:0] offset, // Offset
  input wire logic signed [energy_acc_pkg::GAIN_W-1:0] gain, // Power gain
  output logic signed [energy_acc_pkg::TERM_W-1:0] term_ff, // Corrected term
  output logic negative // Active power sign
);
  logic signed [32:0] prod;
  logic signed [energy_acc_pkg::BUS_W-1:0] bus;
  logic signed [energy_acc_pkg::BUS_W-1:0] lp_ff;
  logic signed [energy_acc_pkg::BUS_W:0] delta;
  logic signed [energy_acc_pkg::BUS_W:0] delta_sh;
  logic signed [energy_acc_pkg::TERM_W-1:0] off_sum;
  logic signed [13:0] factor;
  logic signed [42:0] scaled;

  // Product scaled onto the 28-bit energy bus
  assign prod = volt * curr;
  assign bus = prod[32:energy_acc_pkg::PROD_LSB];

  // First-order low-pass keeps the dc part; ripple averages out later
  assign delta = {bus[energy_acc_pkg::BUS_W-1], bus}
    - {lp_ff[energy_acc_pkg::BUS_W-1], lp_ff};
  assign delta_sh = delta >>> energy_acc_pkg::LPF_SHIFT;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lp_ff <= 28'h0000000;
    else
      lp_ff <= lp_ff + delta_sh[energy_acc_pkg::BUS_W-1:0];
  end

  // Offset at bus scale, then gain as one plus gain over 4096
  assign off_sum = {lp_ff[energy_acc_pkg::BUS_W-1], lp_ff}
    + {{(energy_acc_pkg::TERM_W-energy_acc_pkg::OFFSET_W){offset[11]}},
       offset};
  assign factor = $signed(energy_acc_pkg::GAIN_UNITY)
    + {{2{gain[11]}}, gain};
  assign scaled = off_sum * factor;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      term_ff <= 29'h0000000;
    else
      term_ff <= scaled[40:energy_acc_pkg::GAIN_SHIFT];
  end

  // Negative dc power means more than 90 degrees between v and i
  assign negative = lp_ff[energy_acc_pkg::BUS_W-1];
endmodule : phase_term
